// file: meter_cmd_pkg.sv
package meter_cmd_pkg;

  // Serial framing
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 24;
  localparam int READ_BITS = 32;
  localparam int WR_DATA_BYTES = 3;
  localparam int SYNC_ONES_RUN = 31;

  // Register addressing
  localparam int INDEX_W = 5;
  localparam int PAGE_W = 5;
  localparam logic [4:0] PAGE_SEL_INDEX = 5'h1F;
  localparam logic [4:0] PAGE_RESET = 5'h00;

  // Command encodings
  localparam logic [7:0] SYNC_MASK = 8'hFE;
  localparam logic [7:0] SYNC_CODE = 8'hFE;
  localparam logic [7:0] CONV_MASK = 8'hF7;
  localparam logic [7:0] CONV_CODE = 8'hE0;
  localparam int CONV_CONT_BIT = 3;
  localparam logic [1:0] TOP2_CTRL = 2'h2;
  localparam logic [1:0] PWR_SOFT_RESET = 2'h0;
  localparam logic [1:0] PWR_SLEEP = 2'h1;
  localparam logic [1:0] PWR_WAKE = 2'h2;
  localparam logic [1:0] PWR_STANDBY = 2'h3;
  localparam int WR_BIT = 6;

  // Timing counts
  localparam int TEMP_OWR_SAMPLES = 2240;
  localparam int INIT_CYCLES = 64;
  localparam int CONV_CYCLES = 256;
  localparam int CAL_CYCLES = 512;

  // Line-to-sample ratio default, 0.0125 as a 24-bit fraction (floor)
  localparam logic [23:0] RATIO_DEFAULT = 24'h033333;

  // Flag clear positions
  localparam int CLR_FREQ = 0;
  localparam int CLR_TEMP = 1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_INIT = 6'h02,
    ST_CONV = 6'h04,
    ST_CAL = 6'h08,
    ST_STANDBY = 6'h10,
    ST_SLEEP = 6'h20
  } seq_state_e;

  typedef struct packed {
    logic [4:0] page;
    logic [4:0] index;
  } reg_addr_s;

endpackage

// file: meter_serial_command_decoder.sv
// How it works
// [R1] Bytes shifted most significant bit first
// [R2] Commands are one byte, sampled on shift clock
// [R3] Read returns up to four bytes on data-out
// [R4] Only a new read replaces outgoing data
// [R5] Host sends three data bytes after write
// [R6] Instruction aborts running one, starts new
// [R7] 32 locations per page; page at 31
// [R8] Conversion, power and calibration commands abort running sequences
// [R9] Host only reads or syncs during init
// [R10] Init done flag set after defaults load
// [R11] 0xE0 single, 0xE8 continuous conversion
// [R12] Sync bytes are fillers, otherwise no action
// [R13] Realign on chip select, reset, sync pattern
// [R14] Power code: reset, sleep, wake, standby
// [R15] Wake: standby resumes, sleep fully reinitialises
// [R16] Sleep keeps decoder; standby keeps reference, oscillator
// [R17] Software reset reruns init, power unchanged; here ST_INIT powers core and reference back on
// [R18] Calibration upper two bits give type
// [R19] Lower four bits one-hot channels; zero invalid
// [R20] Auto ratio update sets frequency update flag
// [R21] Temperature refresh every 2240 samples, flagged
// [R22] Automatic channel select unless hold set
// [R23] Read/write byte: 0, W, index, 0
// [R24] Write commits after twenty-fourth data bit
// [R25] Undefined commands are ignored
`timescale 1ns/1ps
`default_nettype none

module meter_serial_command_decoder #(
  parameter int INIT_CYCLES = meter_cmd_pkg::INIT_CYCLES,
  parameter int CONV_CYCLES = meter_cmd_pkg::CONV_CYCLES,
  parameter int CAL_CYCLES = meter_cmd_pkg::CAL_CYCLES,
  parameter int TEMP_SAMPLES = meter_cmd_pkg::TEMP_OWR_SAMPLES,
  parameter int MAG_W = 24
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial port pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  output logic o_sdo,
  // Register map access
  output meter_cmd_pkg::reg_addr_s o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [23:0] o_reg_wdata,
  input wire logic [23:0] i_reg_rdata,
  // Sequencer outputs
  output meter_cmd_pkg::seq_state_e o_state,
  output logic o_continuous,
  output logic [1:0] o_cal_type,
  output logic [3:0] o_cal_chan,
  output logic o_core_power_on,
  output logic o_ref_osc_on,
  // Datapath events and configuration
  input wire logic i_owr_tick,
  input wire logic i_auto_freq_enable,
  input wire logic i_ratio_computed,
  input wire logic [23:0] i_ratio_value,
  output logic [23:0] o_ratio,
  output logic o_temp_refresh,
  // Channel selection
  input wire logic i_chan_hold,
  input wire logic i_sw_chan,
  input wire logic [MAG_W-1:0] i_irms1,
  input wire logic [MAG_W-1:0] i_irms2,
  input wire logic [MAG_W-1:0] i_min_level,
  input wire logic [MAG_W-1:0] i_switch_margin,
  output logic o_energy_chan,
  // Status flags
  input wire logic [1:0] i_flag_clear,
  output logic o_init_done_flag,
  output logic o_freq_update_flag,
  output logic o_temp_update_flag
);

  localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);
  localparam logic [11:0] TEMP_LAST = 12'(TEMP_SAMPLES - 1);

  // Pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic sclk_prev;
  always_ff @(posedge i_clk) begin
    cs_sync <= {cs_sync[0], i_cs_n};
    sclk_sync <= {sclk_sync[0], i_sclk};
    sdi_sync <= {sdi_sync[0], i_sdi};
    sclk_prev <= sclk_sync[1];
  end

  logic cs_n;
  logic sdi;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_n = cs_sync[1];
  assign sdi = sdi_sync[1];
  assign sclk_rise = sclk_sync[1] & ~sclk_prev & ~cs_n;
  assign sclk_fall = ~sclk_sync[1] & sclk_prev & ~cs_n;

  // Receive shifter
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic [4:0] ones_run;
  logic [7:0] rx_byte;
  logic byte_done;
  logic realign;
  assign rx_byte = {rx_shift[6:0], sdi};
  assign byte_done = sclk_rise & (bit_cnt == 3'h7);
  // 3 x sync-one then sync-zero always shows 31 ones then a zero
  assign realign = sclk_rise & ~sdi & (ones_run >= 5'(meter_cmd_pkg::SYNC_ONES_RUN));

  always_ff @(posedge i_clk) begin
    if (i_rst || cs_n) begin
      bit_cnt <= 3'h0; // [R13]
      ones_run <= 5'h00;
    end else if (sclk_rise) begin
      rx_shift <= rx_byte; // [R1] [R2]
      bit_cnt <= realign ? 3'h0 : bit_cnt + 3'h1; // [R13]
      if (!sdi) begin
        ones_run <= 5'h00;
      end else if (ones_run != 5'h1F) begin
        ones_run <= ones_run + 5'h01;
      end
    end
  end

  // Command classification
  logic in_write_data;
  logic cmd_valid;
  logic is_rw;
  logic is_sync;
  logic is_conv;
  logic is_pwr;
  logic is_cal;
  logic is_instr;
  assign cmd_valid = byte_done & ~realign & ~in_write_data;
  assign is_rw = ~rx_byte[7] & ~rx_byte[0]; // [R23]
  assign is_sync = (rx_byte & meter_cmd_pkg::SYNC_MASK) == meter_cmd_pkg::SYNC_CODE; // [R12]
  assign is_conv = (rx_byte & meter_cmd_pkg::CONV_MASK) == meter_cmd_pkg::CONV_CODE; // [R11]
  assign is_pwr = (rx_byte[7:6] == meter_cmd_pkg::TOP2_CTRL) && (rx_byte[3:0] == 4'h0);
  assign is_cal = (rx_byte[7:6] == meter_cmd_pkg::TOP2_CTRL) && (rx_byte[3:0] != 4'h0); // [R19]
  // Anything else falls through untouched
  assign is_instr = cmd_valid & ~is_sync & (is_conv | is_pwr | is_cal); // [R25]

  // Write data collection and register access
  logic [1:0] wr_bytes_left;
  logic [23:0] wr_shift;
  logic [4:0] page;
  logic [4:0] wr_index;
  logic rd_pending;
  assign in_write_data = (wr_bytes_left != 2'h0);

  always_ff @(posedge i_clk) begin
    if (i_rst || cs_n) begin
      wr_bytes_left <= 2'h0;
    end else if (cmd_valid && is_rw && rx_byte[meter_cmd_pkg::WR_BIT]) begin
      wr_bytes_left <= 2'(meter_cmd_pkg::WR_DATA_BYTES); // [R5]
    end else if (byte_done && in_write_data) begin
      wr_bytes_left <= wr_bytes_left - 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (sclk_rise && in_write_data) begin
      wr_shift <= {wr_shift[22:0], sdi}; // [R1]
    end
    if (cmd_valid && is_rw) begin
      wr_index <= rx_byte[5:1]; // [R7]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      page <= meter_cmd_pkg::PAGE_RESET; // [R7]
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_reg_wdata <= 24'h000000;
      o_reg_addr <= '0;
    end else begin
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      if (byte_done && wr_bytes_left == 2'h1) begin
        // Commit only once the last data bit is in
        o_reg_wdata <= {wr_shift[22:0], sdi}; // [R24]
        o_reg_addr <= '{page: page, index: wr_index};
        if (wr_index == meter_cmd_pkg::PAGE_SEL_INDEX) begin
          page <= sdi_page(wr_shift[3:0], sdi); // [R7]
        end else begin
          o_reg_wr <= 1'b1;
        end
      end else if (cmd_valid && is_rw && !rx_byte[meter_cmd_pkg::WR_BIT]) begin
        o_reg_addr <= '{page: page, index: rx_byte[5:1]};
        o_reg_rd <= 1'b1;
      end
    end
  end

  function automatic logic [4:0] sdi_page(input logic [3:0] hi, input logic lo);
    sdi_page = {hi, lo};
  endfunction

  // Read data returns one cycle after the read strobe
  logic [31:0] tx_shift;
  logic skip_fall;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_pending <= 1'b0;
      skip_fall <= 1'b0;
      tx_shift <= 32'h00000000;
      o_sdo <= 1'b0;
    end else begin
      rd_pending <= o_reg_rd;
      // The fall that closes the read byte must not shift the first bit away
      if (cmd_valid && is_rw && !rx_byte[meter_cmd_pkg::WR_BIT]) begin
        skip_fall <= 1'b1; // [R3]
      end else if (sclk_fall || cs_n) begin
        skip_fall <= 1'b0;
      end
      if (rd_pending) begin
        tx_shift <= {i_reg_rdata, 8'h00}; // [R3] [R4]
        o_sdo <= i_reg_rdata[23];
      end else if (sclk_fall && !skip_fall) begin
        tx_shift <= {tx_shift[30:0], 1'b0}; // [R1] [R3]
        o_sdo <= tx_shift[30];
      end
    end
  end

  // Sequencer
  meter_cmd_pkg::seq_state_e state;
  logic [15:0] seq_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= meter_cmd_pkg::ST_INIT;
      seq_cnt <= 16'h0000;
      o_continuous <= 1'b0;
      o_cal_type <= 2'h0;
      o_cal_chan <= 4'h0;
      o_init_done_flag <= 1'b0;
    end else if (is_instr) begin
      // Running work is dropped at once in favour of the new one
      seq_cnt <= 16'h0000; // [R6] [R8]
      if (is_conv) begin
        state <= meter_cmd_pkg::ST_CONV; // [R11]
        o_continuous <= rx_byte[meter_cmd_pkg::CONV_CONT_BIT];
      end else if (is_cal) begin
        state <= meter_cmd_pkg::ST_CAL; // [R18] [R19]
        o_cal_type <= rx_byte[5:4];
        o_cal_chan <= rx_byte[3:0];
      end else begin
        case (rx_byte[5:4]) // [R14]
          meter_cmd_pkg::PWR_SOFT_RESET: begin
            state <= meter_cmd_pkg::ST_INIT; // [R17]
            o_init_done_flag <= 1'b0;
          end
          meter_cmd_pkg::PWR_SLEEP: state <= meter_cmd_pkg::ST_SLEEP;
          meter_cmd_pkg::PWR_STANDBY: state <= meter_cmd_pkg::ST_STANDBY;
          meter_cmd_pkg::PWR_WAKE: begin
            if (state == meter_cmd_pkg::ST_SLEEP) begin
              state <= meter_cmd_pkg::ST_INIT; // [R15]
              o_init_done_flag <= 1'b0;
            end else begin
              state <= meter_cmd_pkg::ST_IDLE; // [R15]
            end
          end
          default: state <= state;
        endcase
      end
    end else begin
      case (state)
        meter_cmd_pkg::ST_INIT: begin
          // Host is expected to hold off all but reads and syncs here
          if (seq_cnt == INIT_LAST) begin // [R9]
            state <= meter_cmd_pkg::ST_IDLE;
            o_init_done_flag <= 1'b1; // [R10]
          end else begin
            seq_cnt <= seq_cnt + 16'h0001;
          end
        end
        meter_cmd_pkg::ST_CONV: begin
          if (seq_cnt == CONV_LAST) begin
            seq_cnt <= 16'h0000;
            if (!o_continuous) begin
              state <= meter_cmd_pkg::ST_IDLE; // [R11]
            end
          end else begin
            seq_cnt <= seq_cnt + 16'h0001;
          end
        end
        meter_cmd_pkg::ST_CAL: begin
          if (seq_cnt == CAL_LAST) begin
            state <= meter_cmd_pkg::ST_IDLE;
          end else begin
            seq_cnt <= seq_cnt + 16'h0001;
          end
        end
        meter_cmd_pkg::ST_IDLE, meter_cmd_pkg::ST_STANDBY, meter_cmd_pkg::ST_SLEEP: begin
          seq_cnt <= 16'h0000;
        end
        default: state <= meter_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_state <= meter_cmd_pkg::ST_INIT;
      o_core_power_on <= 1'b1;
      o_ref_osc_on <= 1'b1;
    end else begin
      o_state <= state;
      o_core_power_on <= (state != meter_cmd_pkg::ST_SLEEP) &&
                         (state != meter_cmd_pkg::ST_STANDBY); // [R16]
      o_ref_osc_on <= (state != meter_cmd_pkg::ST_SLEEP); // [R16]
    end
  end

  // Line-to-sample ratio and frequency update flag
  logic ratio_event;
  assign ratio_event = i_auto_freq_enable & i_ratio_computed;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ratio <= meter_cmd_pkg::RATIO_DEFAULT; // [R20]
      o_freq_update_flag <= 1'b0;
    end else begin
      if (ratio_event) begin
        o_ratio <= i_ratio_value; // [R20]
      end
      // Set beats a clear in the same cycle
      o_freq_update_flag <= ratio_event |
                            (o_freq_update_flag & ~i_flag_clear[meter_cmd_pkg::CLR_FREQ]);
    end
  end

  // Temperature refresh
  logic [11:0] temp_cnt;
  logic temp_event;
  assign temp_event = i_owr_tick && (state == meter_cmd_pkg::ST_CONV) && (temp_cnt == TEMP_LAST);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      temp_cnt <= 12'h000;
      o_temp_refresh <= 1'b0;
      o_temp_update_flag <= 1'b0;
    end else begin
      o_temp_refresh <= temp_event; // [R21]
      if (i_owr_tick && state == meter_cmd_pkg::ST_CONV) begin
        temp_cnt <= temp_event ? 12'h000 : temp_cnt + 12'h001; // [R21]
      end
      o_temp_update_flag <= temp_event |
                            (o_temp_update_flag & ~i_flag_clear[meter_cmd_pkg::CLR_TEMP]);
    end
  end

  // Energy channel selection with hysteresis margin
  logic [MAG_W:0] lim1;
  logic [MAG_W:0] lim2;
  assign lim1 = {1'b0, i_irms1} + {1'b0, i_switch_margin};
  assign lim2 = {1'b0, i_irms2} + {1'b0, i_switch_margin};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_energy_chan <= 1'b0;
    end else if (i_chan_hold) begin
      o_energy_chan <= i_sw_chan; // [R22]
    end else if (!o_energy_chan && {1'b0, i_irms2} > lim1 && i_irms2 >= i_min_level) begin
      o_energy_chan <= 1'b1; // [R22]
    end else if (o_energy_chan && {1'b0, i_irms1} > lim2 && i_irms1 >= i_min_level) begin
      o_energy_chan <= 1'b0; // [R22]
    end
  end

endmodule

`default_nettype wire

// file: meter_serial_command_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module meter_serial_command_decoder_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Observed ports
  input wire logic o_reg_rd,
  input wire logic o_reg_wr,
  input wire meter_cmd_pkg::reg_addr_s o_reg_addr,
  input wire meter_cmd_pkg::seq_state_e o_state,
  input wire logic o_core_power_on,
  input wire logic o_ref_osc_on,
  input wire logic o_temp_refresh,
  input wire logic o_temp_update_flag,
  input wire logic i_auto_freq_enable,
  input wire logic i_ratio_computed,
  input wire logic [23:0] i_ratio_value,
  input wire logic [23:0] o_ratio,
  input wire logic o_freq_update_flag,
  input wire logic o_init_done_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // State output lags, so power is judged once the state has settled
  sequence s_held(st);
    (o_state == st) [*3];
  endsequence
  sequence s_rst_run;
    i_rst [*3];
  endsequence
  // Reset is the cause here, so this one is never disabled
  property p_rst_init;
    disable iff (1'b0) s_rst_run |-> o_state == meter_cmd_pkg::ST_INIT
      && !o_init_done_flag && o_ratio == meter_cmd_pkg::RATIO_DEFAULT;
  endproperty
  property p_init_min; $fell(i_rst) |-> !o_init_done_flag [*8]; endproperty
  property p_rd_pulse; o_reg_rd |=> !o_reg_rd; endproperty
  property p_wr_pulse; o_reg_wr |=> !o_reg_wr; endproperty
  property p_wr_page; o_reg_wr |-> o_reg_addr.index != meter_cmd_pkg::PAGE_SEL_INDEX; endproperty
  property p_sleep; s_held(meter_cmd_pkg::ST_SLEEP) |-> !o_core_power_on && !o_ref_osc_on;
  endproperty
  property p_standby; s_held(meter_cmd_pkg::ST_STANDBY) |-> !o_core_power_on && o_ref_osc_on;
  endproperty
  property p_idle; s_held(meter_cmd_pkg::ST_IDLE) |-> o_core_power_on && o_ref_osc_on;
  endproperty
  property p_temp; o_temp_refresh |-> o_temp_update_flag ##1 !o_temp_refresh; endproperty
  property p_ratio_load;
    i_ratio_computed && i_auto_freq_enable |=> o_ratio == $past(i_ratio_value)
      && o_freq_update_flag;
  endproperty
  property p_ratio_keep; !(i_ratio_computed && i_auto_freq_enable) |=> $stable(o_ratio);
  endproperty
  a_rst_init: assert property (p_rst_init) else $error("reset state wrong");
  a_init_min: assert property (p_init_min) else $error("init done too early");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe long");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe long");
  a_wr_page: assert property (p_wr_page) else $error("page write forwarded");
  a_sleep: assert property (p_sleep) else $error("sleep power wrong");
  a_standby: assert property (p_standby) else $error("standby power wrong");
  a_idle: assert property (p_idle) else $error("active power wrong");
  a_temp: assert property (p_temp) else $error("temp flag not set");
  a_ratio_load: assert property (p_ratio_load) else $error("ratio not loaded");
  a_ratio_keep: assert property (p_ratio_keep) else $error("ratio changed");
endmodule
bind meter_serial_command_decoder meter_serial_command_decoder_asserts i_asserts (
  .i_clk, .i_rst, .o_reg_rd, .o_reg_wr, .o_reg_addr, .o_state, .o_core_power_on,
  .o_ref_osc_on, .o_temp_refresh, .o_temp_update_flag, .i_auto_freq_enable,
  .i_ratio_computed, .i_ratio_value, .o_ratio, .o_freq_update_flag, .o_init_done_flag);
`default_nettype wire

// file: host_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  // Serial port pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b1;
  end
  // Odd split keeps shift edges off the sampling clock
  task automatic put_bit(input logic b, output logic r);
    o_cs_n = 1'b0;
    o_sdi = b;
    #61 o_sclk = 1'b1;
    r = i_sdo;
    #64 o_sclk = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) put_bit(b[k], r[k]);
  endtask
  // Deselected data line shows the inverse, never a stale value
  task automatic release_port();
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #200;
  endtask
endmodule
`default_nettype wire

// file: meter_serial_command_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module meter_serial_command_decoder_test;
  localparam int CONV_N = 600;
  localparam logic [23:0] RDATA = 24'hC3A55A;
  logic clk, rst, cs_n, sclk, sdi, sdo, rd, wr, output_word_rate, afe, rc, hold, swc, ecn;
  logic cont, core, refo, tref, idf, fuf, tuf;
  logic [1:0] ctype, fclr;
  logic [3:0] cchan;
  logic [23:0] wdata, wr_data, rval, ratio, i1, i2, lvl, mrg;
  meter_cmd_pkg::reg_addr_s addr, rd_addr, wr_addr;
  meter_cmd_pkg::seq_state_e st;
  int n_mismatch = 0, comparisons = 0, n_wr = 0, n_tref = 0;
  host_serial_model i_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo));
  meter_serial_command_decoder #(.CONV_CYCLES(CONV_N), .CAL_CYCLES(CONV_N), .TEMP_SAMPLES(4))
    i_meter_serial_command_decoder (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_sdi(sdi), .o_sdo(sdo), .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr),
    .o_reg_wdata(wdata), .i_reg_rdata(RDATA), .o_state(st), .o_continuous(cont),
    .o_cal_type(ctype), .o_cal_chan(cchan), .o_core_power_on(core), .o_ref_osc_on(refo),
    .i_owr_tick(output_word_rate), .i_auto_freq_enable(afe), .i_ratio_computed(rc),
    .i_ratio_value(rval), .o_ratio(ratio), .o_temp_refresh(tref), .i_chan_hold(hold),
    .i_sw_chan(swc), .i_irms1(i1), .i_irms2(i2), .i_min_level(lvl),
    .i_switch_margin(mrg), .o_energy_chan(ecn), .i_flag_clear(fclr),
    .o_init_done_flag(idf), .o_freq_update_flag(fuf), .o_temp_update_flag(tuf));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd) rd_addr <= addr;
    if (wr) begin
      n_wr++;
      wr_addr <= addr;
      wr_data <= wdata;
    end
    if (tref) n_tref++;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_st(input meter_cmd_pkg::seq_state_e s, input int lim);
    for (int n = 0; n < lim && st !== s; n++) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] b);
    logic [7:0] r;
    i_host.xfer(b, r);
    repeat (8) @(negedge clk);
  endtask
  task automatic t_reset();
    `CHK("state", meter_cmd_pkg::ST_INIT, st)
    `CHK("power", 2'h3, {core, refo})
    wait_st(meter_cmd_pkg::ST_IDLE, 200);
    `CHK("done", 1'b1, idf)
  endtask
  // Fillers and an instruction go in while read data comes out
  task automatic t_read();
    logic [7:0] r [5];
    logic [7:0] fill [4] = '{8'hFF, 8'hE8, 8'hFE, 8'hFF};
    i_host.xfer(8'h04, r[0]);
    for (int k = 0; k < 4; k++) i_host.xfer(fill[k], r[k + 1]);
    `CHK("rdata", {RDATA, 8'h00}, {r[1], r[2], r[3], r[4]})
    `CHK("raddr", 10'h002, rd_addr)
    `CHK("state", meter_cmd_pkg::ST_CONV, st)
    `CHK("cont", 1'b1, cont)
  endtask
  // Data bytes look like instructions and must not act as ones
  task automatic t_write();
    logic [7:0] r;
    logic [7:0] bs [8] = '{8'h7E, 8'h00, 8'h00, 8'h03, 8'h42, 8'hE0, 8'h90, 8'hA0};
    int w0;
    w0 = n_wr;
    for (int k = 0; k < 8; k++) i_host.xfer(bs[k], r);
    repeat (8) @(negedge clk);
    `CHK("writes", w0 + 1, n_wr)
    `CHK("waddr", 10'h061, wr_addr)
    `CHK("wdata", 24'hE090A0, wr_data)
    `CHK("state", meter_cmd_pkg::ST_CONV, st)
  endtask
  task automatic t_realign();
    logic [7:0] r [2];
    logic b;
    i_host.put_bit(1'b1, b);
    for (int k = 0; k < 4; k++) i_host.xfer(8'hFF, r[0]);
    i_host.xfer(8'hFE, r[0]);
    i_host.xfer(8'h04, r[0]);
    i_host.xfer(8'hFF, r[1]);
    `CHK("rdata", RDATA[23:16], r[1])
    i_host.put_bit(1'b0, b);
    i_host.release_port();
    i_host.xfer(8'h04, r[0]);
    i_host.xfer(8'hFF, r[1]);
    `CHK("rdata", RDATA[23:16], r[1])
  endtask
  task automatic t_power();
    logic [7:0] pc [5] = '{8'h90, 8'hA0, 8'hB0, 8'hA0, 8'h80};
    logic [5:0] pe [5] = '{6'h20, 6'h02, 6'h10, 6'h01, 6'h02};
    for (int k = 0; k < 5; k++) begin
      cmd(pc[k]);
      `CHK("state", pe[k], st)
      `CHK("ref", pe[k] != 6'h20, refo)
      `CHK("core", pe[k] < 6'h10, core)
      if (pe[k] == 6'h02) wait_st(meter_cmd_pkg::ST_IDLE, 200);
    end
    `CHK("done", 1'b1, idf)
  endtask
  task automatic t_cal();
    logic [7:0] cc [4] = '{8'h84, 8'h9F, 8'hA3, 8'hB8};
    for (int k = 0; k < 4; k++) begin
      cmd(cc[k]);
      `CHK("state", meter_cmd_pkg::ST_CAL, st)
      `CHK("caltype", cc[k][5:4], ctype)
      `CHK("calchan", cc[k][3:0], cchan)
    end
    cmd(8'hE0);
    `CHK("cont", 1'b0, cont)
    cmd(8'hC0);
    `CHK("state", meter_cmd_pkg::ST_CONV, st)
    wait_st(meter_cmd_pkg::ST_IDLE, CONV_N);
    `CHK("state", meter_cmd_pkg::ST_IDLE, st)
  endtask
  task automatic t_temp();
    int n0;
    cmd(8'hE8);
    @(negedge clk) fclr = 2'h2;
    @(negedge clk) fclr = 2'h0;
    `CHK("tempflag", 1'b0, tuf)
    n0 = n_tref;
    repeat (7) begin
      @(negedge clk) output_word_rate = 1'b1;
      @(negedge clk) output_word_rate = 1'b0;
      repeat (2) @(negedge clk);
    end
    `CHK("refresh", n0 + 1, n_tref)
    `CHK("tempflag", 1'b1, tuf)
    @(negedge clk) fclr = 2'h2;
    @(negedge clk) fclr = 2'h0;
    `CHK("tempclr", 1'b0, tuf)
  endtask
  task automatic ratio_pulse(input logic en, input logic [23:0] v);
    @(negedge clk);
    afe = en;
    rval = v;
    rc = 1'b1;
    @(negedge clk) rc = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_freq();
    ratio_pulse(1'b0, 24'h0ABCDE);
    `CHK("ratio", meter_cmd_pkg::RATIO_DEFAULT, ratio)
    ratio_pulse(1'b1, 24'h0F5C29);
    `CHK("ratio", 24'h0F5C29, ratio)
    `CHK("freqflag", 1'b1, fuf)
    @(negedge clk) fclr = 2'h1;
    @(negedge clk) fclr = 2'h0;
    `CHK("freqclr", 1'b0, fuf)
  endtask
  task automatic chan(input logic [23:0] a, input logic h, input logic s);
    @(negedge clk);
    i1 = a;
    hold = h;
    swc = s;
    repeat (6) @(negedge clk);
  endtask
  // Channel two sits at 24'h0000C8, margin 24'h00000A
  task automatic t_chan();
    chan(24'h000032, 1'b0, 1'b0);
    `CHK("chan", 1'b1, ecn)
    chan(24'h0000CD, 1'b0, 1'b0);
    `CHK("chan", 1'b1, ecn)
    chan(24'h00012C, 1'b0, 1'b1);
    `CHK("chan", 1'b0, ecn)
    chan(24'h00012C, 1'b1, 1'b1);
    `CHK("chan", 1'b1, ecn)
  endtask
  initial begin
    rst = 1'b1;
    {output_word_rate, afe, rc, hold, swc} = 5'h00;
    fclr = 2'h0;
    rval = 24'h000000;
    i1 = 24'h000000;
    i2 = 24'h0000C8;
    lvl = 24'h000064;
    mrg = 24'h00000A;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_read();
    t_write();
    t_realign();
    t_power();
    t_cal();
    t_temp();
    t_freq();
    t_chan();
    give_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    $display("Watchdog expired before the tests ended");
    give_verdict();
  end
endmodule
`default_nettype wire
